// *** hdl/spm_pin_mux.sv ***
// pin-function mux, power-down and interrupt control of the serializer parallel side
`timescale 1ns/1ps
// Contract
// - the audio bit clock, word clock and first data pins may each become a register-driven output.
// - in 18-bit mode the shared blue pin carries a second audio data channel, chosen by pin or register.
// - the second audio data pin may instead serve as blue bit one or as output five.
// - the four two-way general-purpose pins exist only in 18-bit mode, chosen by pin or register.
// - the general-purpose pins map to green one, green zero, red one and red zero, high to low.
// - outputs four to eight are driven at levels held in a configuration register.
// - the device runs while power_down_bar is high and powers down while it is low.
// - while powered down both serial outputs sit high and the clock multiplier is off.
// - while powered down all control registers return to their reset values.
// - any pending interrupt whose mask bit is set pulls the open-drain interrupt_out_low low, else it floats high.
// - the serial control target address follows the level on bus_address_select unless the pin_cfg override bit is set.
module spm_pin_mux #(
   parameter int ADDR_W = 7
) (
   input wire logic clk,
   input wire logic rst,
   // AXI4-Lite slave
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // pins
   input wire logic power_down_bar,
   input wire logic mode18_pin,
   input wire logic [ADDR_W-1:0] bus_address_select,
   input wire logic prot_irq_event,
   input wire spm_pkg::spm_pins_t pins_in,
   output spm_pkg::spm_pins_t pins_out,
   output spm_pkg::spm_pins_t pins_oe,
   output spm_pkg::spm_pins_t core_in,
   output logic [ADDR_W-1:0] bus_target_addr,
   output logic serial_out_p,
   output logic serial_out_n,
   input wire logic serial_data,
   output logic pll_enable,
   output logic interrupt_out_low_o,
   output logic interrupt_out_low_oe
);
   // two-flop synchronisers for pins
   logic pd_s1_q, pd_s2_q, m18_s1_q, m18_s2_q;
   logic [ADDR_W-1:0] adr_s1_q, adr_s2_q;
   spm_pkg::spm_pins_t pin_s1_q, pin_s2_q;
   always_ff @(posedge clk) begin
      pd_s1_q <= power_down_bar;
      pd_s2_q <= pd_s1_q;
      m18_s1_q <= mode18_pin;
      m18_s2_q <= m18_s1_q;
      adr_s1_q <= bus_address_select;
      adr_s2_q <= adr_s1_q;
      pin_s1_q <= pins_in;
      pin_s2_q <= pin_s1_q;
   end

   logic pd_active;
   logic ctl_rst;
   assign pd_active = ~pd_s2_q;
   assign ctl_rst = rst | pd_active;

   // status width comes first: the status and mask registers below are sized by it
   localparam int IRQ_W_L = spm_pkg::IRQ_W;
   logic [31:0] pin_cfg_q, gpo_val_q, gpio_cfg_q;
   logic [IRQ_W_L-1:0] int_stat_q, int_mask_q;

   // decoded configuration
   logic mode18;
   logic [2:0] aud_gpo;
   spm_pkg::spm_db_sel_t db_sel;
   logic b0_gpo;
   // pin or register chooses 18-bit mode
   assign mode18 = pin_cfg_q[spm_pkg::CFG_MODE18_SRC_POS] ? pin_cfg_q[spm_pkg::CFG_MODE18_POS]
                                                         : m18_s2_q;
   assign aud_gpo = pin_cfg_q[spm_pkg::CFG_AUD_GPO_POS +: 3];
   assign db_sel = spm_pkg::spm_db_sel_t'(pin_cfg_q[spm_pkg::CFG_DB_SEL_POS +: 2]);
   assign b0_gpo = pin_cfg_q[spm_pkg::CFG_B0_GPO_POS];

   // output drivers and enables for every shared pin
   always_comb begin
      pins_out = '0;
      pins_oe = '0;
      // audio pins as outputs eight, seven, six
      pins_oe.aud_clk = aud_gpo[2];
      pins_oe.aud_wc = aud_gpo[1];
      pins_oe.aud_da = aud_gpo[0];
      // levels from gpo value register bits 8:4
      pins_out.aud_clk = gpo_val_q[8];
      pins_out.aud_wc = gpo_val_q[7];
      pins_out.aud_da = gpo_val_q[6];
      // second audio pin as output five
      pins_oe.aud_db = (db_sel == spm_pkg::SPM_DB_GPO);
      pins_out.aud_db = gpo_val_q[5];
      pins_oe.blue0 = b0_gpo;
      pins_out.blue0 = gpo_val_q[4];
      // gpio drive only in 18-bit mode
      // gpio3..0 on green1, green0, red1, red0
      pins_oe.gpio = mode18 ? gpio_cfg_q[3:0] : 4'h0;
      pins_out.gpio = gpo_val_q[3:0];
   end

   // video/audio path into the core, with repurposed pins masked
   always_comb begin
      core_in = pin_s2_q;
      // repurposed pins stop feeding the core
      if (aud_gpo[2]) begin
         core_in.aud_clk = 1'b0;
      end
      if (aud_gpo[1]) begin
         core_in.aud_wc = 1'b0;
      end
      if (aud_gpo[0]) begin
         core_in.aud_da = 1'b0;
      end
      if (b0_gpo) begin
         core_in.blue0 = 1'b0;
      end
      if (mode18) begin
         core_in.gpio = 4'h0;
      end
      // second audio channel only in 18-bit mode
      // or routed to blue bit one
      unique case (db_sel)
         spm_pkg::SPM_DB_AUDIO: begin
            core_in.aud_db = mode18 ? pin_s2_q.aud_db : 1'b0;
         end
         spm_pkg::SPM_DB_BLUE1: begin
            core_in.blue1 = pin_s2_q.aud_db;
            core_in.aud_db = 1'b0;
         end
         default: begin
            core_in.aud_db = 1'b0;
         end
      endcase
   end

   // address from strap, register may override
   assign bus_target_addr = pin_cfg_q[spm_pkg::CFG_ADDR_OVR_POS]
                          ? pin_cfg_q[spm_pkg::CFG_ADDR_POS +: ADDR_W] : adr_s2_q;

   // serial outputs parked high, multiplier off
   // both legs high is a steady idle that the far end cannot take for data
   assign serial_out_p = pd_active ? 1'b1 : serial_data;
   assign serial_out_n = pd_active ? 1'b1 : ~serial_data;
   assign pll_enable = ~pd_active;

   // interrupt events: protection, gpio input change, power-down exit
   logic [3:0] gpio_prev_q;
   logic pd_prev_q;
   logic [IRQ_W_L-1:0] irq_ev;
   // history flops carry no reset; they settle while reset is held
   always_ff @(posedge clk) begin
      gpio_prev_q <= pin_s2_q.gpio;
      pd_prev_q <= pd_active;
   end
   assign irq_ev = {pd_prev_q & ~pd_active,
                    mode18 & |((pin_s2_q.gpio ^ gpio_prev_q) & ~gpio_cfg_q[3:0]),
                    prot_irq_event};

   // open drain, pulled low while a pending bit has its mask bit set
   assign interrupt_out_low_o = 1'b0;
   assign interrupt_out_low_oe = |(int_stat_q & int_mask_q);

   // AXI4-Lite write channel: address and data taken in either order
   logic aw_have_q, w_have_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_go;
   assign s_awready = ~aw_have_q & ~s_bvalid;
   assign s_wready = ~w_have_q & ~s_bvalid;
   assign wr_go = aw_have_q & w_have_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         s_bvalid <= 1'b0;
         s_bresp <= spm_pkg::RESP_OKAY;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_wdata;
            w_strb_q <= s_wstrb;
         end
         if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= addr_ok(aw_addr_q) ? spm_pkg::RESP_OKAY : spm_pkg::RESP_SLVERR;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   // mapped-address check shared by both channels
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == spm_pkg::ADDR_PIN_CFG) || (a == spm_pkg::ADDR_GPO_VAL) ||
                (a == spm_pkg::ADDR_GPIO_CFG) || (a == spm_pkg::ADDR_GPIO_IN) ||
                (a == spm_pkg::ADDR_INT_STAT) || (a == spm_pkg::ADDR_INT_MASK) ||
                (a == spm_pkg::ADDR_STATUS);
   endfunction

   // byte-lane merge used by pin_cfg_q, gpo_val_q and gpio_cfg_q
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] st);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   // control registers; power-down returns them to reset values
   always_ff @(posedge clk) begin
      if (ctl_rst) begin
         pin_cfg_q <= spm_pkg::PIN_CFG_RST;
         gpo_val_q <= spm_pkg::ZERO_RST;
         gpio_cfg_q <= spm_pkg::ZERO_RST;
         int_mask_q <= '0;
      end else if (wr_go) begin
         unique case (aw_addr_q)
            spm_pkg::ADDR_PIN_CFG: pin_cfg_q <= merge(pin_cfg_q, w_data_q, w_strb_q);
            spm_pkg::ADDR_GPO_VAL: gpo_val_q <= merge(gpo_val_q, w_data_q, w_strb_q);
            spm_pkg::ADDR_GPIO_CFG: gpio_cfg_q <= merge(gpio_cfg_q, w_data_q, w_strb_q);
            spm_pkg::ADDR_INT_MASK: begin
               if (w_strb_q[0]) begin
                  int_mask_q <= w_data_q[IRQ_W_L-1:0];
               end
            end
            default: ;
         endcase
      end
   end

   // sticky status, write one to clear; a new event wins over the clear
   logic [IRQ_W_L-1:0] w1c;
   assign w1c = (wr_go && aw_addr_q == spm_pkg::ADDR_INT_STAT && w_strb_q[0])
              ? w_data_q[IRQ_W_L-1:0] : '0;
   always_ff @(posedge clk) begin
      if (rst) begin
         int_stat_q <= '0;
      end else begin
         int_stat_q <= (int_stat_q & ~w1c) | irq_ev;
      end
   end

   // read channel, one cycle after the address is taken
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      unique case (s_araddr)
         spm_pkg::ADDR_PIN_CFG: rd_mux = pin_cfg_q;
         spm_pkg::ADDR_GPO_VAL: rd_mux = gpo_val_q;
         spm_pkg::ADDR_GPIO_CFG: rd_mux = gpio_cfg_q;
         spm_pkg::ADDR_GPIO_IN: rd_mux = {28'h000_0000, pin_s2_q.gpio};
         spm_pkg::ADDR_INT_STAT: rd_mux = {29'h0000_0000, int_stat_q};
         spm_pkg::ADDR_INT_MASK: rd_mux = {29'h0000_0000, int_mask_q};
         // status: [0] powered down, [1] 18-bit mode, [14:8] target address
         spm_pkg::ADDR_STATUS: rd_mux = {17'h0_0000, bus_target_addr, 6'h00, mode18, pd_active};
         default: rd_mux = '0;
      endcase
   end
   // rd_mux follows s_araddr live, so it is only sampled on the taking edge
   assign s_arready = ~s_rvalid;
   always_ff @(posedge clk) begin
      if (rst) begin
         s_rvalid <= 1'b0;
         s_rdata <= '0;
         s_rresp <= spm_pkg::RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_rvalid <= 1'b1;
         s_rdata <= rd_mux;
         s_rresp <= addr_ok(s_araddr) ? spm_pkg::RESP_OKAY : spm_pkg::RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
         s_rvalid <= 1'b0;
      end
   end
endmodule // spm_pin_mux

// *** include/spm_pkg.sv ***
// package for the serializer pin-function mux
package spm_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_PIN_CFG = 8'h00;
   localparam logic [7:0] ADDR_GPO_VAL = 8'h04;
   localparam logic [7:0] ADDR_GPIO_CFG = 8'h08;
   localparam logic [7:0] ADDR_GPIO_IN = 8'h0C;
   localparam logic [7:0] ADDR_INT_STAT = 8'h10;
   localparam logic [7:0] ADDR_INT_MASK = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   // pin_cfg field positions
   localparam int CFG_MODE18_POS = 0;
   localparam int CFG_MODE18_SRC_POS = 1;
   localparam int CFG_AUD_GPO_POS = 2;
   localparam int CFG_DB_SEL_POS = 5;
   localparam int CFG_B0_GPO_POS = 7;
   localparam int CFG_ADDR_OVR_POS = 8;
   localparam int CFG_ADDR_POS = 9;
   // reset values
   localparam logic [31:0] PIN_CFG_RST = 32'h0000_0000;
   localparam logic [31:0] ZERO_RST = 32'h0000_0000;
   // interrupt status bits
   localparam int IRQ_PROT_POS = 0;
   localparam int IRQ_GPIO_POS = 1;
   localparam int IRQ_PD_POS = 2;
   localparam int IRQ_W = 3;
   // second audio data pin function
   typedef enum logic [1:0] {SPM_DB_AUDIO, SPM_DB_BLUE1, SPM_DB_GPO} spm_db_sel_t;
   // gathered AXI4-Lite response codes
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // shared pin group, as seen by the core
   typedef struct packed {
      logic aud_clk;
      logic aud_wc;
      logic aud_da;
      logic aud_db;
      logic blue1;
      logic blue0;
      logic [3:0] gpio;
   } spm_pins_t;
endpackage

// *** sim/spm_host_model.sv ***
// host side of the shared pins: device drive wins, else host level
`timescale 1ns/1ps
module spm_host_model (
   input spm_pkg::spm_pins_t pins_out,
   input spm_pkg::spm_pins_t pins_oe,
   input spm_pkg::spm_pins_t host_val,
   output spm_pkg::spm_pins_t pins_in
);
   // host backs off wherever the device drives, avoiding contention
   assign pins_in = spm_pkg::spm_pins_t'((pins_out & pins_oe) | (host_val & ~pins_oe));
endmodule // spm_host_model

// *** sim/spm_pin_mux_props.sv ***
// concurrent checks on the pin-function mux ports
`timescale 1ns/1ps
module spm_pin_mux_props #(
   parameter int ADDR_W = 7
) (
   input logic clk,
   input logic rst,
   input logic power_down_bar,
   input logic serial_data,
   input logic serial_out_p,
   input logic serial_out_n,
   input logic pll_enable,
   input logic interrupt_out_low_o,
   input logic interrupt_out_low_oe,
   input spm_pkg::spm_pins_t pins_oe,
   input logic [ADDR_W-1:0] bus_address_select,
   input logic [ADDR_W-1:0] bus_target_addr,
   input logic s_awvalid,
   input logic s_awready,
   input logic s_wvalid,
   input logic s_wready,
   input logic s_bvalid,
   input logic s_bready,
   input logic [1:0] s_bresp,
   input logic s_arvalid,
   input logic s_arready,
   input logic s_rvalid,
   input logic s_rready,
   input logic [31:0] s_rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // four samples cover the two-flop synchroniser on the pin
   sequence pd_held;
      (!power_down_bar)[*4];
   endsequence
   sequence run_held;
      power_down_bar[*4];
   endsequence
   sequence wr_taken;
      s_awvalid && s_awready && s_wvalid && s_wready;
   endsequence
   a_pd_serial_high: assert property (pd_held |-> serial_out_p && serial_out_n)
      else $error("serial outputs not parked high");
   a_pd_pll_off: assert property (pd_held |-> !pll_enable)
      else $error("clock multiplier left on");
   a_run_serial_data: assert property (run_held |-> serial_out_p == serial_data
      && serial_out_n == !serial_data)
      else $error("serial outputs not following data");
   a_pd_pins_released: assert property (pd_held |-> pins_oe == '0)
      else $error("shared pin driven in power-down");
   a_strap_addr_used: assert property ((!power_down_bar && $stable(bus_address_select))[*4]
      |-> bus_target_addr == bus_address_select)
      else $error("target address not from strap");
   a_irq_open_drain: assert property (!interrupt_out_low_o)
      else $error("interrupt line driven high");
   // the mask is a control register, so power-down silences the line
   a_pd_irq_quiet: assert property (pd_held |-> !interrupt_out_low_oe)
      else $error("interrupt pending in power-down");
   a_bresp_held: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
      else $error("write response dropped");
   a_rdata_held: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
      else $error("read data dropped");
   a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (wr_taken |-> ##[1:2] s_bvalid)
      else $error("write answer late");
endmodule // spm_pin_mux_props
bind spm_pin_mux spm_pin_mux_props #(.ADDR_W(ADDR_W)) i_props (.clk, .rst, .power_down_bar,
   .serial_data, .serial_out_p, .serial_out_n, .pll_enable, .interrupt_out_low_o,
   .interrupt_out_low_oe, .pins_oe, .bus_address_select, .bus_target_addr, .s_awvalid,
   .s_awready, .s_wvalid, .s_wready, .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready,
   .s_rvalid, .s_rready, .s_rdata);

// *** sim/testbench.sv ***
// self-checking bench for the pin-function mux
`timescale 1ns/1ps
module testbench;
   logic clk = 0, rst = 1, s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
   logic s_rready = 0, power_down_bar = 1, mode18_pin = 0, prot_irq_event = 0, serial_data = 0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, serial_out_p, serial_out_n;
   logic pll_enable, interrupt_out_low_o, interrupt_out_low_oe;
   logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
   logic [31:0] s_wdata = 32'h0000_0000, s_rdata, rd;
   logic [3:0] s_wstrb = 4'h0;
   logic [1:0] s_bresp, s_rresp, rsp;
   logic [6:0] bus_address_select = 7'h2A, bus_target_addr;
   spm_pkg::spm_pins_t pins_in, pins_out, pins_oe, core_in;
   spm_pkg::spm_pins_t host_val = '0;
   int err_count = 0, num_checks = 0;
   // open-drain line with its pull-up
   wire int_line = interrupt_out_low_oe ? interrupt_out_low_o : 1'b1;
   always #2 clk = ~clk;
   spm_pin_mux #(.ADDR_W(7)) i_dut (.clk, .rst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
      .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
      .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .power_down_bar, .mode18_pin,
      .bus_address_select, .prot_irq_event, .pins_in, .pins_out, .pins_oe, .core_in,
      .bus_target_addr, .serial_out_p, .serial_out_n, .serial_data, .pll_enable,
      .interrupt_out_low_o, .interrupt_out_low_oe);
   spm_host_model i_host (.pins_out, .pins_oe, .host_val, .pins_in);
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // handshakes are looked at mid-cycle; each channel lets go on the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ad, wd, bd;
      bd = 0;
      s_awaddr <= a;
      s_wdata <= d;
      s_wstrb <= 4'hF;
      s_awvalid <= 1;
      s_wvalid <= 1;
      s_bready <= 1;
      while (!bd) begin
         @(negedge clk);
         ad = s_awvalid && s_awready;
         wd = s_wvalid && s_wready;
         bd = s_bvalid;
         if (bd) rsp = s_bresp;
         @(posedge clk);
         if (ad) s_awvalid <= 0;
         if (wd) s_wvalid <= 0;
         if (bd) s_bready <= 0;
      end
      // one idle edge so the next call never reassigns a strobe in this step
      @(posedge clk);
   endtask
   task automatic rc(input string w, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
      logic an, rn;
      rn = 0;
      s_araddr <= a;
      s_arvalid <= 1;
      s_rready <= 1;
      while (!rn) begin
         @(negedge clk);
         an = s_arvalid && s_arready;
         rn = s_rvalid;
         if (rn) rd = s_rdata;
         if (rn) rsp = s_rresp;
         @(posedge clk);
         if (an) s_arvalid <= 0;
         if (rn) s_rready <= 0;
      end
      @(posedge clk);
      check(w, rd & m, e);
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // watchdog, far beyond the roughly 120 cycles the sequence needs
   initial begin
      #20000;
      err_count++;
      complete_run;
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      rc("pin_cfg", spm_pkg::ADDR_PIN_CFG, 32'hFFFF_FFFF, spm_pkg::PIN_CFG_RST);
      rc("unmapped", 8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
      check("rresp", rsp, spm_pkg::RESP_SLVERR);
      check("strap addr", bus_target_addr, 32'h0000_002A);
      wr(spm_pkg::ADDR_PIN_CFG, 32'h0000_2B00);
      check("override addr", bus_target_addr, 32'h0000_0015);
      wr(spm_pkg::ADDR_GPO_VAL, 32'h0000_016A);
      wr(spm_pkg::ADDR_GPIO_CFG, 32'h0000_000F);
      wr(spm_pkg::ADDR_PIN_CFG, 32'h0000_00DF);
      check("gpo", {pins_out.aud_clk, pins_out.aud_wc, pins_out.aud_da, pins_out.aud_db,
         pins_out.blue0}, 32'h0000_0016);
      check("gpo oe", {pins_oe.aud_clk, pins_oe.aud_wc, pins_oe.aud_da, pins_oe.aud_db,
         pins_oe.blue0}, 32'h0000_001F);
      check("gpio out", pins_out.gpio, 32'h0000_000A);
      check("gpio oe", pins_oe.gpio, 32'h0000_000F);
      wr(spm_pkg::ADDR_GPIO_CFG, 32'h0000_0000);
      host_val.gpio <= 4'h5;
      repeat (4) @(posedge clk);
      check("core masked", {core_in.aud_clk, core_in.aud_wc, core_in.aud_da, core_in.aud_db,
         core_in.blue0, core_in.gpio}, 32'h0000_0000);
      rc("gpio in", spm_pkg::ADDR_GPIO_IN, 32'h0000_000F, 32'h0000_0005);
      wr(spm_pkg::ADDR_GPIO_CFG, 32'h0000_000F);
      wr(spm_pkg::ADDR_PIN_CFG, 32'h0000_0002);
      check("gpio oe off", pins_oe.gpio, 32'h0000_0000);
      // mode by pin, then by register
      wr(spm_pkg::ADDR_PIN_CFG, 32'h0000_0000);
      mode18_pin <= 1;
      host_val.aud_db <= 1;
      repeat (4) @(posedge clk);
      check("second audio", core_in.aud_db, 32'h0000_0001);
      rc("mode pin", spm_pkg::ADDR_STATUS, 32'h0000_0002, 32'h0000_0002);
      mode18_pin <= 0;
      wr(spm_pkg::ADDR_PIN_CFG, 32'h0000_0003);
      rc("mode reg", spm_pkg::ADDR_STATUS, 32'h0000_0002, 32'h0000_0002);
      wr(spm_pkg::ADDR_PIN_CFG, 32'h0000_0023);
      check("blue one", {core_in.blue1, core_in.aud_db}, 32'h0000_0002);
      // raise, mask and clear the protection request; a set mask bit lets it through
      wr(spm_pkg::ADDR_INT_MASK, 32'h0000_0001);
      wr(spm_pkg::ADDR_INT_STAT, 32'h0000_0007);
      check("int idle", int_line, 32'h0000_0001);
      prot_irq_event <= 1;
      @(posedge clk) prot_irq_event <= 0;
      repeat (2) @(posedge clk);
      check("int low", int_line, 32'h0000_0000);
      rc("int stat", spm_pkg::ADDR_INT_STAT, 32'h0000_0001, 32'h0000_0001);
      wr(spm_pkg::ADDR_INT_MASK, 32'h0000_0000);
      check("int masked", int_line, 32'h0000_0001);
      wr(spm_pkg::ADDR_INT_MASK, 32'h0000_0001);
      wr(spm_pkg::ADDR_INT_STAT, 32'h0000_0001);
      check("int cleared", int_line, 32'h0000_0001);
      wr(spm_pkg::ADDR_PIN_CFG, 32'h0000_00DF);
      serial_data <= 1;
      @(posedge clk) power_down_bar <= 0;
      check("serial run", {serial_out_p, serial_out_n}, 32'h0000_0002);
      repeat (4) @(posedge clk);
      check("serial parked", {serial_out_p, serial_out_n}, 32'h0000_0003);
      check("pll off", pll_enable, 32'h0000_0000);
      rc("pd status", spm_pkg::ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
      wr(spm_pkg::ADDR_PIN_CFG, 32'h0000_0001);
      power_down_bar <= 1;
      repeat (4) @(posedge clk);
      rc("cfg after pd", spm_pkg::ADDR_PIN_CFG, 32'hFFFF_FFFF, spm_pkg::PIN_CFG_RST);
      check("pll on", pll_enable, 32'h0000_0001);
      complete_run;
   end
endmodule // testbench
